// ---- common/aam_pkg.sv ----
// Constants for the alarm annunciation manager
package aam_pkg;
   // Clock and base tick
   localparam int CLK_NS = 50;
   localparam int TICK_MS = 10;
   localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;
   // Times in milliseconds, as specified
   localparam int TONE_MS = 80;
   localparam int HALF_S_MS = 500;
   localparam int TWO_S_MS = 2000;
   localparam int HP_PER_MS = 3000;
   localparam int MP_PER_MS = 6000;
   localparam int INFO_PER_MS = 5000;
   localparam int PAUSE_MS = 60000;
   localparam int DWELL_MS = 2000;
   localparam int PF_HOLD_MS = 1000;
   // Same times in ticks; TW is the 13-bit timer width
   localparam int TONE_T = TONE_MS / TICK_MS;
   localparam int SLOT_T = 2 * TONE_T;
   localparam int HALF_T = HALF_S_MS / TICK_MS;
   localparam int TWO_T = TWO_S_MS / TICK_MS;
   localparam int HP_PER_T = HP_PER_MS / TICK_MS;
   localparam int HP2_T = 3 * SLOT_T + HALF_T;
   localparam int MP_PER_T = MP_PER_MS / TICK_MS;
   localparam int INFO_T = INFO_PER_MS / TICK_MS;
   localparam int PAUSE_T = PAUSE_MS / TICK_MS;
   localparam int DWELL_T = DWELL_MS / TICK_MS;
   localparam int PF_HOLD_T = PF_HOLD_MS / TICK_MS;
   localparam int TW = 13;
   // Register byte offsets
   localparam logic [7:0] ADDR_COND = 8'h00;
   localparam logic [7:0] ADDR_LIM = 8'h04;
   localparam logic [7:0] ADDR_SND = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   // Limit field positions, units of 0.5 cmH2O
   localparam int LIM_HI_LSB = 0;
   localparam int LIM_LO_LSB = 8;
   localparam int LIM_OFF_BIT = 16;
   localparam logic [6:0] HI_MIN = 7'h0a;
   localparam logic [6:0] HI_MAX = 7'h3c;
   localparam logic [6:0] LO_MIN = 7'h02;
   localparam logic [6:0] LO_MAX = 7'h32;
   localparam logic [6:0] HI_RST = 7'h28;
   localparam logic [6:0] LO_RST = 7'h02;
   // Sound level in dBA; breaths at limit before the high pressure alarm
   localparam logic [6:0] SND_MIN = 7'h37;
   localparam logic [6:0] SND_MAX = 7'h50;
   localparam logic [6:0] SND_RST = 7'h46;
   localparam logic [1:0] HP_BREATHS = 2'h3;
endpackage : aam_pkg

// ---- logic/aam_tick.sv ----
// Base tick divider for the alarm annunciation manager
`timescale 1ns/1ns
module aam_tick #(
   parameter int CYC = 200000
) (
   input wire logic hclk,
   input wire logic hresetn,
   output logic tick_r
);
   import aam_pkg::*;
   logic [17:0] cnt_r;

   // One-cycle enable every CYC clocks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 18'h00000;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (cnt_r == 18'(CYC - 1));
         cnt_r <= (cnt_r == 18'(CYC - 1)) ? 18'h00000 : cnt_r + 18'h00001;
      end
   end
endmodule : aam_tick

// ---- logic/aam_tmr.sv ----
// Tick period counter with restart, used for every pattern timer
`timescale 1ns/1ns
module aam_tmr #(
   parameter int PER = 100
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input wire logic restart,
   output logic [12:0] cnt_r,
   output logic wrap
);
   import aam_pkg::*;
   wire last = (cnt_r == 13'(PER - 1));

   // Restart wins over counting so a pattern always begins at zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 13'h0000;
      end else if (restart) begin
         cnt_r <= 13'h0000;
      end else if (tick) begin
         cnt_r <= last ? 13'h0000 : cnt_r + 13'h0001;
      end
   end

   assign wrap = tick & ~restart & last;
endmodule : aam_tmr

// ---- logic/aam_top.sv ----
// Alarm annunciation manager: tones, lamp, display loop, pause, high pressure
`timescale 1ns/1ns
module aam_top #(
   parameter int TICK_CYCLES = aam_pkg::TICK_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [6:0] pressure,
   input wire logic breath_end,
   input wire logic pause_btn,
   input wire logic info_pend,
   input wire logic power_fail,
   output logic tone_r,
   output logic info_tone_r,
   output logic remote_r,
   output logic lamp_red_r,
   output logic lamp_yel_r,
   output logic disp_on_r,
   output logic [3:0] disp_idx_r,
   output logic disp_more_r,
   output logic disp_red_r,
   output logic disp_yel_r,
   output logic [6:0] snd_lvl_r,
   output logic breath_stop_r,
   output logic power_down_r
);
   import aam_pkg::*;

   logic tick;
   logic [5:0] cond_hp_r;
   logic [7:0] cond_mp_r;
   logic [6:0] hi_lim_r, lo_lim_r;
   logic hi_off_r, wr_err_r, pf_r, pause_r, hpress_r, in_hit_r, lamp_ph_r, any_hp_prev_r;
   logic [1:0] hp_cnt_r;
   logic [6:0] pf_cnt_r;
   logic [7:0] hp_prev_r, mp_prev_r;
   logic dp_wr_r;
   logic [7:0] dp_addr_r;
   logic [12:0] hcnt, mcnt, icnt, lcnt;
   logic pwrap, dwrap;

   // Alarm vectors follow live conditions plus hpress_r, held between breaths, and pf_r, latched until reset
   wire [7:0] hp_vec = {hpress_r, pf_r, cond_hp_r};
   wire [7:0] mp_vec = cond_mp_r;
   wire any_hp = |hp_vec;
   wire any_mp = |mp_vec;
   wire any = any_hp | any_mp;
   wire new_alm = |(hp_vec & ~hp_prev_r) | |(mp_vec & ~mp_prev_r);

   // Pause state: a new alarm beats both the button and the expiry
   wire pause_nxt = new_alm ? 1'b0 :
                    (pause_btn ? ~pause_r :
                    (pwrap ? 1'b0 : pause_r));
   wire seq_rst = new_alm | ~any | (pause_r & ~pause_nxt);

   // Tone windows inside a sequence period
   function automatic logic in_burst(input logic [12:0] d, input int n);
      in_burst = (int'(d) < n * SLOT_T) && ((int'(d) % SLOT_T) < TONE_T);
   endfunction : in_burst

   wire hp_pat = in_burst(hcnt, 3) |
                 ((int'(hcnt) >= HP2_T) && in_burst(hcnt - 13'(HP2_T), 2));
   wire mp_pat = in_burst(mcnt, 3);
   wire tone_nxt = ~pause_r & (any_hp ? hp_pat : (any_mp & mp_pat));

   // Lamp half period follows the higher priority present
   wire [12:0] lamp_half = any_hp ? 13'(HALF_T) : 13'(TWO_T);
   wire lamp_flip = tick & (lcnt == lamp_half - 13'h0001);
   wire prio_chg = any_hp != any_hp_prev_r;
   wire lamp_rst = ~any | prio_chg | lamp_flip;

   // Display loop over the shown priority only
   wire [15:0] disp_vec = any_hp ? {8'h00, hp_vec} : {mp_vec, 8'h00};
   wire multi = |(disp_vec & (disp_vec - 16'h0001));
   wire cur_ok = disp_vec[disp_idx_r];

   function automatic logic [3:0] nxt_idx(input logic [15:0] v, input logic [3:0] cur);
      logic [3:0] k;
      logic found;
      nxt_idx = cur;
      found = 1'b0;
      for (int i = 1; i <= 16; i++) begin
         k = cur + 4'(i);
         if (!found && v[k]) begin
            nxt_idx = k;
            found = 1'b1;
         end
      end
   endfunction : nxt_idx

   // High pressure detection on the live pressure sample
   wire reach = ~hi_off_r & (pressure >= hi_lim_r);
   wire hit = in_hit_r | reach;

   // Register bus decode
   wire ap_ok = hsel & htrans[1] & hready;
   wire [7:0] ap_addr = haddr[7:0];
   wire wr_cond = dp_wr_r & (dp_addr_r == ADDR_COND);
   wire wr_lim = dp_wr_r & (dp_addr_r == ADDR_LIM);
   wire wr_snd = dp_wr_r & (dp_addr_r == ADDR_SND);
   wire [6:0] w_hi = hwdata[LIM_HI_LSB +: 7];
   wire [6:0] w_lo = hwdata[LIM_LO_LSB +: 7];
   wire w_off = hwdata[LIM_OFF_BIT];
   wire lo_ok = (w_lo >= LO_MIN) & (w_lo <= LO_MAX);
   wire hi_ok = w_off | ((w_hi >= HI_MIN) & (w_hi <= HI_MAX) & (w_hi >= w_lo));
   wire lim_ok = lo_ok & hi_ok;
   wire [6:0] w_snd = hwdata[6:0];
   wire snd_ok = (w_snd >= SND_MIN) & (w_snd <= SND_MAX);
   wire [31:0] stat = {16'h0000, disp_idx_r, 2'h0, hp_cnt_r, wr_err_r, pf_r,
                       hpress_r, pause_r, any_mp, any_hp, tone_r, remote_r};
   wire [31:0] rd_mux = (ap_addr == ADDR_COND) ? {16'h0000, cond_mp_r, 2'h0, cond_hp_r} :
                        (ap_addr == ADDR_LIM) ? {15'h0000, hi_off_r, 1'b0, lo_lim_r,
                                                1'b0, hi_lim_r} :
                        (ap_addr == ADDR_SND) ? {25'h0000000, snd_lvl_r} :
                        (ap_addr == ADDR_STAT) ? stat : 32'h00000000;

   aam_tick #(.CYC(TICK_CYCLES)) u_tick (
      .hclk(hclk), .hresetn(hresetn), .tick_r(tick)
   );
   aam_tmr #(.PER(HP_PER_T)) u_hp (
      .hclk(hclk), .hresetn(hresetn), .tick(tick), .restart(seq_rst),
      .cnt_r(hcnt), .wrap()
   );
   aam_tmr #(.PER(MP_PER_T)) u_mp (
      .hclk(hclk), .hresetn(hresetn), .tick(tick), .restart(seq_rst),
      .cnt_r(mcnt), .wrap()
   );
   aam_tmr #(.PER(INFO_T)) u_info (
      .hclk(hclk), .hresetn(hresetn), .tick(tick), .restart(~info_pend),
      .cnt_r(icnt), .wrap()
   );
   aam_tmr #(.PER(TWO_T)) u_lamp (
      .hclk(hclk), .hresetn(hresetn), .tick(tick), .restart(lamp_rst),
      .cnt_r(lcnt), .wrap()
   );
   aam_tmr #(.PER(PAUSE_T)) u_pause (
      .hclk(hclk), .hresetn(hresetn), .tick(tick), .restart(~pause_r),
      .cnt_r(), .wrap(pwrap)
   );
   // Dwell restarts when the shown alarm leaves, so each new entry gets a full dwell
   aam_tmr #(.PER(DWELL_T)) u_dwell (
      .hclk(hclk), .hresetn(hresetn), .tick(tick), .restart(~any | ~cur_ok),
      .cnt_r(), .wrap(dwrap)
   );

   // Bus slave: zero wait states, read data captured in the address phase.
   // The master idles between transfers, so a read never races a write.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
      end else begin
         dp_wr_r <= ap_ok & hwrite;
         dp_addr_r <= ap_addr;
         if (ap_ok && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Settings persist across a power fail; only hresetn clears them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cond_hp_r <= 6'h00;
         cond_mp_r <= 8'h00;
         hi_lim_r <= HI_RST;
         lo_lim_r <= LO_RST;
         hi_off_r <= 1'b0;
         snd_lvl_r <= SND_RST;
         wr_err_r <= 1'b0;
      end else begin
         if (wr_cond) begin
            cond_hp_r <= hwdata[5:0];
            cond_mp_r <= hwdata[15:8];
         end
         if (wr_lim && lim_ok) begin
            hi_lim_r <= w_hi;
            lo_lim_r <= w_lo;
            hi_off_r <= w_off;
         end
         if (wr_snd && snd_ok) begin
            snd_lvl_r <= w_snd;
         end
         if (wr_lim || wr_snd) begin
            wr_err_r <= wr_lim ? ~lim_ok : ~snd_ok;
         end
      end
   end

   // Breath counting; the stop pulse fires once, on the first sample at limit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_hit_r <= 1'b0;
         hp_cnt_r <= 2'h0;
         hpress_r <= 1'b0;
         breath_stop_r <= 1'b0;
      end else begin
         breath_stop_r <= reach & ~in_hit_r;
         if (breath_end) begin
            in_hit_r <= 1'b0;
            if (hit) begin
               hp_cnt_r <= (hp_cnt_r == HP_BREATHS) ? HP_BREATHS : hp_cnt_r + 2'h1;
               if (hp_cnt_r == HP_BREATHS - 2'h1) begin
                  hpress_r <= 1'b1;
               end
            end else begin
               hp_cnt_r <= 2'h0;
               hpress_r <= 1'b0;
            end
         end else begin
            in_hit_r <= hit;
         end
      end
   end

   // Power fail: sound the alarm for a hold time, then request power down
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pf_r <= 1'b0;
         pf_cnt_r <= 7'h00;
         power_down_r <= 1'b0;
      end else begin
         pf_r <= pf_r | power_fail;
         if (pf_r && tick && pf_cnt_r != 7'(PF_HOLD_T)) begin
            pf_cnt_r <= pf_cnt_r + 7'h01;
         end
         power_down_r <= pf_r & (pf_cnt_r == 7'(PF_HOLD_T));
      end
   end

   // Annunciation outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hp_prev_r <= 8'h00;
         mp_prev_r <= 8'h00;
         any_hp_prev_r <= 1'b0;
         pause_r <= 1'b0;
         tone_r <= 1'b0;
         info_tone_r <= 1'b0;
         remote_r <= 1'b0;
         lamp_ph_r <= 1'b0;
         lamp_red_r <= 1'b0;
         lamp_yel_r <= 1'b0;
      end else begin
         hp_prev_r <= hp_vec;
         mp_prev_r <= mp_vec;
         any_hp_prev_r <= any_hp;
         pause_r <= pause_nxt;
         tone_r <= tone_nxt;
         info_tone_r <= info_pend & (icnt < 13'(TONE_T));
         remote_r <= any;
         lamp_ph_r <= (~any | prio_chg) ? 1'b1 : (lamp_flip ? ~lamp_ph_r : lamp_ph_r);
         lamp_red_r <= any_hp & lamp_ph_r;
         lamp_yel_r <= ~any_hp & any_mp & lamp_ph_r;
      end
   end

   // Display: move on at dwell end, or at once if the shown alarm left
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         disp_idx_r <= 4'h0;
         disp_on_r <= 1'b0;
         disp_more_r <= 1'b0;
         disp_red_r <= 1'b0;
         disp_yel_r <= 1'b0;
      end else begin
         if (!cur_ok || dwrap) begin
            disp_idx_r <= nxt_idx(disp_vec, disp_idx_r);
         end
         disp_on_r <= any;
         disp_more_r <= multi;
         disp_red_r <= any_hp;
         disp_yel_r <= ~any_hp & any_mp;
      end
   end

   a_alarm_remote: assert property (@(posedge hclk) disable iff (!hresetn)
      new_alm |=> remote_r) else $error("remote output missed a new alarm");
   a_pause_cancel: assert property (@(posedge hclk) disable iff (!hresetn)
      new_alm |=> !pause_r) else $error("pause survived a new alarm");
   a_pause_second: assert property (@(posedge hclk) disable iff (!hresetn)
      pause_r && pause_btn |=> !pause_r) else $error("second press kept pause");
   a_tone_muted: assert property (@(posedge hclk) disable iff (!hresetn)
      pause_r [*2] |-> !tone_r) else $error("tone sounded while paused");
   a_disp_prec: assert property (@(posedge hclk) disable iff (!hresetn)
      disp_yel_r |-> !$past(any_hp)) else $error("medium shown during high alarm");
   a_more_mark: assert property (@(posedge hclk) disable iff (!hresetn)
      disp_more_r |-> $past(multi)) else $error("marker without further alarms");
   a_lamp_prio: assert property (@(posedge hclk) disable iff (!hresetn)
      lamp_yel_r |-> !$past(any_hp)) else $error("yellow lamp during high alarm");
   a_press_three: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(hpress_r) |-> $past(hp_cnt_r) == 2'h2 && $past(breath_end))
      else $error("high pressure raised early");
   a_press_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(hpress_r) |-> $past(breath_end) && !$past(hit))
      else $error("high pressure cleared without a clean breath");
   a_breath_stop: assert property (@(posedge hclk) disable iff (!hresetn)
      reach && !in_hit_r && !breath_end |=> breath_stop_r ##1 !breath_stop_r)
      else $error("breath not ended at limit");
   a_lim_legal: assert property (@(posedge hclk) disable iff (!hresetn)
      hi_off_r || (hi_lim_r >= lo_lim_r && hi_lim_r >= HI_MIN && hi_lim_r <= HI_MAX))
      else $error("illegal high pressure limit held");
   a_snd_range: assert property (@(posedge hclk) disable iff (!hresetn)
      snd_lvl_r >= SND_MIN && snd_lvl_r <= SND_MAX) else $error("sound level out of range");
endmodule : aam_top

// ---- test/aam_remote_unit.sv ----
// Remote alarm unit model on the cable side of the annunciation manager
`timescale 1ns/1ns
module aam_remote_unit (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic remote_r,
   output logic [7:0] alert_cnt_r
);
   logic seen_r;
   // Counts alarm onsets; a level that stays high is one alarm, not many
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_r <= 1'b0;
         alert_cnt_r <= 8'h00;
      end else begin
         seen_r <= remote_r;
         if (remote_r && !seen_r) alert_cnt_r <= alert_cnt_r + 8'h01;
      end
   end
endmodule : aam_remote_unit

// ---- test/aam_tb_top.sv ----
// Self-checking bench for the alarm annunciation manager
`timescale 1ns/1ns
module aam_tb_top;
   import aam_pkg::*;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hready, breath_end, pause_btn, info_pend, power_fail;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [6:0] pressure, snd_lvl_r;
   logic hreadyout, hresp, tone_r, info_tone_r, remote_r, lamp_red_r, lamp_yel_r;
   logic disp_on_r, disp_more_r, disp_red_r, disp_yel_r, breath_stop_r, power_down_r;
   logic [3:0] disp_idx_r;
   logic [7:0] alert_cnt;
   int num_errors = 0;
   int num_checks = 0;
   // 20 MHz clock; the single slave drives the bus ready
   always #25 hclk = ~hclk;
   assign hready = hreadyout;
   // Short tick of 4 clocks keeps the 60 s pause inside the run
   aam_top #(.TICK_CYCLES(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pressure(pressure), .breath_end(breath_end), .pause_btn(pause_btn),
      .info_pend(info_pend), .power_fail(power_fail), .tone_r(tone_r),
      .info_tone_r(info_tone_r), .remote_r(remote_r), .lamp_red_r(lamp_red_r),
      .lamp_yel_r(lamp_yel_r), .disp_on_r(disp_on_r), .disp_idx_r(disp_idx_r),
      .disp_more_r(disp_more_r), .disp_red_r(disp_red_r), .disp_yel_r(disp_yel_r),
      .snd_lvl_r(snd_lvl_r), .breath_stop_r(breath_stop_r), .power_down_r(power_down_r));
   aam_remote_unit i_remote (.hclk(hclk), .hresetn(hresetn), .remote_r(remote_r),
      .alert_cnt_r(alert_cnt));
   task automatic report_and_stop;
      if (num_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic fail(input string msg);
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask : fail
   task automatic chk_bit(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) fail(what);
   endtask : chk_bit
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
   endtask : chk_word
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   // Ready is sampled at each edge; a slave that never answers ends the run
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (n >= 40) begin
         fail("bus wait timed out");
         report_and_stop();
      end
   endtask : wait_rdy
   // Single word transfer; an idle cycle after writes avoids stale read-back
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
      if (wr) cyc(1);
   endtask : ahb
   task automatic press;
      pause_btn <= 1'b1;
      cyc(1);
      pause_btn <= 1'b0;
   endtask : press
   // One breath; pressure drops before the end pulse so no reach leaks over
   task automatic breath(input logic [6:0] p, input logic stop);
      logic seen;
      seen = 1'b0;
      pressure <= p;
      repeat (5) begin
         @(posedge hclk);
         seen = seen | breath_stop_r;
      end
      chk_bit(seen, stop, "breath stop pulse");
      pressure <= 7'h00;
      cyc(1);
      breath_end <= 1'b1;
      cyc(1);
      breath_end <= 1'b0;
      cyc(3);
   endtask : breath
   task automatic t_regs;
      logic [31:0] wd[9] = '{32'h36, 32'h37, 32'h50, 32'h51, 32'h209, 32'h20a, 32'h23d,
         32'h140a, 32'h10214};
      logic [31:0] ex[9] = '{32'h46, 32'h37, 32'h50, 32'h50, 32'h228, 32'h20a, 32'h20a,
         32'h20a, 32'h10214};
      logic [7:0] ad;
      ahb(1'b0, ADDR_LIM, 32'h0);
      chk_word(rd, 32'h228, "limit reset");
      ahb(1'b0, ADDR_SND, 32'h0);
      chk_word(rd, 32'h46, "sound reset");
      foreach (wd[i]) begin
         ad = (i < 4) ? ADDR_SND : ADDR_LIM;
         ahb(1'b1, ad, wd[i]);
         chk_bit(hresp, 1'b0, "refused write still okay");
         ahb(1'b0, ad, 32'h0);
         chk_word(rd, ex[i], "setting range");
         ahb(1'b0, ADDR_STAT, 32'h0);
         chk_bit(rd[7], wd[i] != ex[i], "refusal flag");
      end
      chk_word({25'h0, snd_lvl_r}, 32'h50, "sound level out");
      ahb(1'b1, 8'h10, 32'hffff);
      ahb(1'b0, 8'h10, 32'h0);
      chk_word(rd, 32'h0, "unmapped read");
   endtask : t_regs
   task automatic t_info;
      int n, gap;
      logic prev, rise;
      gap = 0;
      info_pend <= 1'b1;
      repeat (2) begin
         n = 0;
         prev = info_tone_r;
         do begin
            @(posedge hclk);
            n++;
            rise = info_tone_r === 1'b1 && prev !== 1'b1;
            prev = info_tone_r;
         end while (!rise && n < 2100);
         if (!rise) begin
            fail("info tone timed out");
            report_and_stop();
         end
         gap = n;
      end
      chk_bit(gap > 1990 && gap < 2010, 1'b1, "info tone period");
      chk_bit(tone_r, 1'b0, "info is not an alarm tone");
      info_pend <= 1'b0;
   endtask : t_info
   // Times in clocks after the alarm write; windows sit mid-tone or mid-gap
   task automatic t_high;
      int tt[8] = '{48, 80, 112, 144, 300, 416, 950, 1216};
      logic [7:0] tn = 8'b10101010;
      logic [7:0] lr = 8'b11101111;
      int now;
      ahb(1'b1, ADDR_COND, 32'h1);
      cyc(3);
      now = 4;
      chk_bit(remote_r, 1'b1, "remote at once");
      chk_bit(tone_r, 1'b1, "tone at once");
      chk_bit(disp_red_r & disp_on_r & ~disp_yel_r, 1'b1, "red highlight");
      foreach (tt[i]) begin
         cyc(tt[i] - now);
         now = tt[i];
         chk_bit(tone_r, tn[i], "high tone pattern");
         chk_bit(lamp_red_r, lr[i], "red lamp flash");
      end
      chk_bit(tone_r, 1'b1, "three second restart");
      chk_word({24'h0, alert_cnt}, 32'h1, "remote unit alarm");
      ahb(1'b1, ADDR_COND, 32'h101);
      cyc(4);
      chk_bit(lamp_yel_r | disp_yel_r | disp_more_r, 1'b0, "medium hidden");
      chk_word({28'h0, disp_idx_r}, 32'h0, "high shown");
   endtask : t_high
   task automatic t_pause;
      press();
      repeat (40) begin
         cyc(32);
         chk_bit(tone_r, 1'b0, "muted");
      end
      press();
      cyc(3);
      chk_bit(tone_r, 1'b1, "second press unmutes");
      press();
      cyc(3);
      ahb(1'b1, ADDR_COND, 32'h103);
      cyc(2);
      chk_bit(tone_r, 1'b1, "new alarm unmutes");
      chk_bit(disp_more_r, 1'b1, "more marker");
      press();
      cyc(23900);
      chk_bit(tone_r, 1'b0, "still muted");
      cyc(116);
      chk_bit(tone_r, 1'b1, "pause expired");
   endtask : t_pause
   task automatic t_med;
      ahb(1'b1, ADDR_COND, 32'h300);
      cyc(3);
      chk_bit(lamp_yel_r & ~lamp_red_r & disp_yel_r & ~disp_red_r, 1'b1, "yellow");
      chk_bit(tone_r & disp_more_r, 1'b1, "medium tone and marker");
      chk_word({28'h0, disp_idx_r}, 32'h8, "first medium");
      cyc(397);
      chk_bit(tone_r, 1'b0, "medium gap");
      cyc(600);
      chk_bit(lamp_yel_r, 1'b0, "yellow slow flash");
      chk_word({28'h0, disp_idx_r}, 32'h9, "loop next");
      cyc(216);
      chk_bit(tone_r, 1'b0, "no three second repeat");
      cyc(1200);
      chk_bit(tone_r & remote_r, 1'b1, "six second repeat");
      ahb(1'b1, ADDR_COND, 32'h0);
      cyc(3);
      chk_bit(remote_r | tone_r | disp_on_r, 1'b0, "cleared");
   endtask : t_med
   task automatic t_hpress;
      ahb(1'b1, ADDR_LIM, 32'h214);
      breath(7'h19, 1'b1);
      breath(7'h19, 1'b1);
      ahb(1'b0, ADDR_STAT, 32'h0);
      chk_bit(rd[5], 1'b0, "two breaths");
      breath(7'h19, 1'b1);
      ahb(1'b0, ADDR_STAT, 32'h0);
      chk_bit(rd[5] & remote_r, 1'b1, "three breaths");
      chk_word({28'h0, disp_idx_r}, 32'h7, "pressure shown");
      breath(7'h0a, 1'b0);
      ahb(1'b0, ADDR_STAT, 32'h0);
      chk_bit(rd[5], 1'b0, "low breath clears");
   endtask : t_hpress
   task automatic t_pfail;
      power_fail <= 1'b1;
      cyc(4);
      chk_bit(remote_r, 1'b1, "power alarm");
      cyc(296);
      chk_bit(power_down_r, 1'b0, "alarm before power off");
      cyc(120);
      chk_bit(power_down_r, 1'b1, "power off");
      ahb(1'b0, ADDR_LIM, 32'h0);
      chk_word(rd, 32'h214, "settings kept");
      chk_word({24'h0, alert_cnt}, 32'h3, "remote unit onsets");
   endtask : t_pfail
   // Main sequence: reset for ten clocks, then the scenarios in turn
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, breath_end, pause_btn, info_pend, power_fail} = 6'h00;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      pressure = 7'h00;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_info();
      t_high();
      t_pause();
      t_med();
      t_hpress();
      t_pfail();
      report_and_stop();
   end
endmodule : aam_tb_top
